// ==== core/ftapb_defs.svh ====
// offsets, field positions, reset values and timing counts of the audio property bank
`ifndef FTAPB_DEFS_SVH
`define FTAPB_DEFS_SVH

// register indices; byte address is four times the index
`define FTAPB_IDX_CONTROL       14'h0000
`define FTAPB_IDX_STATUS        14'h0001
`define FTAPB_IDX_MASK          14'h0002
`define FTAPB_IDX_LINE_MUTE     14'h2105
`define FTAPB_IDX_PREEMPHASIS   14'h2106
`define FTAPB_IDX_PILOT_FREQ    14'h2107
`define FTAPB_IDX_DRC_ENABLE    14'h2200
`define FTAPB_IDX_COMP_THRESH   14'h2201
`define FTAPB_IDX_COMP_ATTACK   14'h2202

// field positions
`define FTAPB_BIT_RIGHT_SILENCE 0
`define FTAPB_BIT_LEFT_SILENCE  1
`define FTAPB_BIT_COMPRESSOR_ON 0
`define FTAPB_BIT_PEAK_CLAMP_ON 1
`define FTAPB_BIT_POWERED_UP    0
`define FTAPB_BIT_PILOT_ENABLE  1
`define FTAPB_EVT_CTS           0
`define FTAPB_EVT_REFUSED       1
`define FTAPB_EVT_COMPRESS      2

// reset values
`define FTAPB_RST_LINE_MUTE     2'h0
`define FTAPB_RST_PREEMPHASIS   2'h0
`define FTAPB_RST_PILOT_FREQ    16'h4A38
`define FTAPB_RST_DRC_ENABLE    2'h2
`define FTAPB_RST_COMP_THRESH   16'hFFD8
`define FTAPB_RST_COMP_ATTACK   4'h0
`define FTAPB_RST_CONTROL       2'h0

// limits and timing
`define FTAPB_ATTACK_MAX_CODE   4'h9
`define FTAPB_BUSY_CYCLES       4'h4
`define FTAPB_CLK_PERIOD_NS     50
`define FTAPB_ATTACK_STEP_NS    500000
`define FTAPB_ATTACK_STEP_CYC   (`FTAPB_ATTACK_STEP_NS / `FTAPB_CLK_PERIOD_NS)

`endif

// ==== core/ftapb_pkg.sv ====
// types shared by the audio property bank
package ftapb_pkg;

  typedef enum logic [1:0] {
    CTS_READY = 2'b01,
    CTS_BUSY  = 2'b10
  } ftapb_cts_type;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } ftapb_stereo_type;

  typedef struct packed {
    logic [1:0]  emphasis_select;
    logic [15:0] pilot_freq;
    logic        pilot_active;
    logic        peak_clamp_on;
    logic        compressor_on;
    logic [15:0] threshold;
    logic [3:0]  attack_code;
    logic        compression_region;
  } ftapb_audio_cfg_type;

  typedef struct packed {
    ftapb_cts_type    cts;
    logic [3:0]       busy_cnt;
    logic [1:0]       line_mute;
    logic [1:0]       emphasis_select;
    logic [15:0]      pilot_freq;
    logic [1:0]       drc_enable;
    logic [15:0]      threshold;
    logic [3:0]       attack_code;
    logic [1:0]       control;
    logic [2:0]       status;
    logic [2:0]       mask;
    logic [19:0]      attack_cnt;
    logic             compress;
    logic             pilot_active;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq;
    ftapb_stereo_type audio;
  } ftapb_state_type;

endpackage : ftapb_pkg

// ==== core/ftapb_bank.sv ====
// audio property bank with apb slave, clear-to-send and audio path controls
// Contract
// R1 - left input silenced while left mute bit set
// R2 - right input silenced while right mute bit set
// R3 - two-bit code selects 75us, 50us, off
// R4 - pilot frequency in 1 Hz, reset 19000
// R5 - pilot only while component pilot bit set
// R6 - host clears data-service bit for test tones
// R7 - clear-to-send rises once next command accepted
// R8 - property access only while powered up
// R9 - limiter follows bit 1, reset on
// R10 - compressor follows bit 0, reset off
// R11 - host keeps limiter off on old firmware
// R12 - threshold signed dBFS, reset minus forty
// R13 - gain below threshold, compression above it
// R14 - attack code n gives (n+1) half-milliseconds
// R15 - attack time delays entry into compression
// R16 - reserved bits ignored on write, read zero
// R17 - muted channel feeds zero samples downstream
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ftapb_defs.svh"

module ftapb_bank #(
  parameter int unsigned ATTACK_STEP_CYCLES = `FTAPB_ATTACK_STEP_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [15:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  output var  logic                          irq,
  output var  logic                          cts,
  input  wire ftapb_pkg::ftapb_stereo_type   audio_in,
  input  wire logic signed [15:0]            audio_level,
  output var  ftapb_pkg::ftapb_stereo_type   audio_out,
  output var  ftapb_pkg::ftapb_audio_cfg_type audio_cfg
);
  import ftapb_pkg::*;

  ftapb_state_type s_reg;
  ftapb_state_type s_next;

  function automatic logic is_property(input logic [15:0] addr);
    logic [13:0] idx;
    idx = addr[15:2];
    is_property = (idx == `FTAPB_IDX_LINE_MUTE) || (idx == `FTAPB_IDX_PREEMPHASIS) ||
                  (idx == `FTAPB_IDX_PILOT_FREQ) || (idx == `FTAPB_IDX_DRC_ENABLE) ||
                  (idx == `FTAPB_IDX_COMP_THRESH) || (idx == `FTAPB_IDX_COMP_ATTACK);
  endfunction : is_property

  function automatic logic [19:0] attack_limit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `FTAPB_ATTACK_MAX_CODE) ? `FTAPB_ATTACK_MAX_CODE : code;
    attack_limit = 20'((c + 4'h1) * ATTACK_STEP_CYCLES);
  endfunction : attack_limit

  logic access;
  logic prop_hit;
  logic above_thresh;
  assign access       = psel && penable && !s_reg.pready;
  assign prop_hit     = is_property(paddr);
  assign above_thresh = $signed(audio_level) > $signed(s_reg.threshold);

  // write taken by the bank while powered up and ready
  logic wr_taken;
  assign wr_taken = access && pwrite && (s_reg.cts == CTS_READY) && s_reg.control[`FTAPB_BIT_POWERED_UP];

  always_comb
  begin
    logic [2:0]  set_evt;
    logic [2:0]  clr_evt;
    logic [15:0] rd;
    set_evt = 3'h0;
    clr_evt = 3'h0;
    rd      = 16'h0000;
    s_next  = s_reg;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    // clear-to-send countdown after a property access
    if (s_reg.cts == CTS_BUSY)
    begin
      if (s_reg.busy_cnt == 4'h0)
      begin
        s_next.cts = CTS_READY; // R7
        set_evt[`FTAPB_EVT_CTS] = 1'b1; // R7
      end
      else
      begin
        s_next.busy_cnt = s_reg.busy_cnt - 4'h1;
      end
    end
    // property access waits in access phase until ready
    if (access && (!prop_hit || s_reg.cts == CTS_READY)) // R7
    begin
      s_next.pready = 1'b1;
      if (prop_hit && !s_reg.control[`FTAPB_BIT_POWERED_UP])
      begin
        s_next.pslverr = 1'b1; // R8
        set_evt[`FTAPB_EVT_REFUSED] = 1'b1; // R8
      end
      else
      begin
        // reserved bits dropped on write, zero on read
        case (paddr[15:2]) // R16
          `FTAPB_IDX_CONTROL:
          begin
            rd = {14'h0000, s_reg.control};
            if (pwrite)
              s_next.control = pwdata[1:0];
          end
          `FTAPB_IDX_STATUS:
          begin
            rd = {13'h0000, s_reg.status};
            if (pwrite)
              clr_evt = pwdata[2:0];
          end
          `FTAPB_IDX_MASK:
          begin
            rd = {13'h0000, s_reg.mask};
            if (pwrite)
              s_next.mask = pwdata[2:0];
          end
          `FTAPB_IDX_LINE_MUTE:
          begin
            rd = {14'h0000, s_reg.line_mute};
            if (pwrite)
              s_next.line_mute = pwdata[1:0]; // R1 R2
          end
          `FTAPB_IDX_PREEMPHASIS:
          begin
            rd = {14'h0000, s_reg.emphasis_select};
            if (pwrite)
              s_next.emphasis_select = pwdata[1:0]; // R3
          end
          `FTAPB_IDX_PILOT_FREQ:
          begin
            rd = s_reg.pilot_freq;
            if (pwrite)
              s_next.pilot_freq = pwdata[15:0]; // R4
          end
          `FTAPB_IDX_DRC_ENABLE:
          begin
            rd = {14'h0000, s_reg.drc_enable};
            if (pwrite)
              s_next.drc_enable = pwdata[1:0]; // R9 R10
          end
          `FTAPB_IDX_COMP_THRESH:
          begin
            rd = s_reg.threshold;
            if (pwrite)
              s_next.threshold = pwdata[15:0]; // R12
          end
          `FTAPB_IDX_COMP_ATTACK:
          begin
            rd = {12'h000, s_reg.attack_code};
            if (pwrite)
              s_next.attack_code = pwdata[3:0]; // R14
          end
          default:
          begin
            s_next.pslverr = 1'b1;
          end
        endcase
        if (prop_hit)
        begin
          s_next.cts      = CTS_BUSY; // R7
          s_next.busy_cnt = `FTAPB_BUSY_CYCLES - 4'h1;
        end
      end
      s_next.prdata = {16'h0000, rd};
    end
    // muted channels feed zero samples
    s_next.audio.left  = s_reg.line_mute[`FTAPB_BIT_LEFT_SILENCE] ? 16'sh0000 : audio_in.left; // R1 R17
    s_next.audio.right = s_reg.line_mute[`FTAPB_BIT_RIGHT_SILENCE] ? 16'sh0000 : audio_in.right; // R2 R17
    // gain region below threshold, compression after attack time above it
    if (!s_reg.drc_enable[`FTAPB_BIT_COMPRESSOR_ON] || !above_thresh) // R10 R13
    begin
      s_next.attack_cnt = 20'h00000;
      s_next.compress   = 1'b0;
    end
    else if (!s_reg.compress)
    begin
      if (s_reg.attack_cnt >= attack_limit(s_reg.attack_code) - 20'h00001) // R14 R15
      begin
        s_next.compress = 1'b1; // R13 R15
        set_evt[`FTAPB_EVT_COMPRESS] = 1'b1;
      end
      else
      begin
        s_next.attack_cnt = s_reg.attack_cnt + 20'h00001;
      end
    end
    s_next.pilot_active = s_reg.control[`FTAPB_BIT_PILOT_ENABLE] &&
                          s_reg.control[`FTAPB_BIT_POWERED_UP]; // R5
    // sticky events, a new event wins over its clear
    s_next.status = (s_reg.status & ~clr_evt) | set_evt;
    s_next.irq    = |(s_next.status & s_next.mask);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg                 <= '0;
      s_reg.cts             <= CTS_READY;
      s_reg.line_mute       <= `FTAPB_RST_LINE_MUTE;
      s_reg.emphasis_select <= `FTAPB_RST_PREEMPHASIS; // R3
      s_reg.pilot_freq      <= `FTAPB_RST_PILOT_FREQ; // R4
      s_reg.drc_enable      <= `FTAPB_RST_DRC_ENABLE; // R9 R10
      s_reg.threshold       <= `FTAPB_RST_COMP_THRESH; // R12
      s_reg.attack_code     <= `FTAPB_RST_COMP_ATTACK; // R14
      s_reg.control         <= `FTAPB_RST_CONTROL;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prdata    = s_reg.prdata;
  assign pready    = s_reg.pready;
  assign pslverr   = s_reg.pslverr;
  assign irq       = s_reg.irq;
  assign cts       = s_reg.cts[0];
  assign audio_out = s_reg.audio;
  assign audio_cfg = '{emphasis_select:    s_reg.emphasis_select,
                       pilot_freq:         s_reg.pilot_freq,
                       pilot_active:       s_reg.pilot_active,
                       peak_clamp_on:      s_reg.drc_enable[`FTAPB_BIT_PEAK_CLAMP_ON],
                       compressor_on:      s_reg.drc_enable[`FTAPB_BIT_COMPRESSOR_ON],
                       threshold:          s_reg.threshold,
                       attack_code:        s_reg.attack_code,
                       compression_region: s_reg.compress};

  // checks
  chk_left_mute_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    s_reg.line_mute[`FTAPB_BIT_LEFT_SILENCE] |=> (audio_out.left == 16'sh0000))
    else $error("left output not silenced while muted");

  chk_right_mute_pass: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    !s_reg.line_mute[`FTAPB_BIT_RIGHT_SILENCE] |=> (audio_out.right == $past(audio_in.right)))
    else $error("right output not passed while unmuted");

  chk_emph_write_only: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
    $changed(audio_cfg.emphasis_select) |-> $past(access && pwrite && s_reg.control[0] &&
      paddr[15:2] == `FTAPB_IDX_PREEMPHASIS))
    else $error("emphasis changed without a write");

  chk_pilot_freq_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    $changed(audio_cfg.pilot_freq) |-> $past(pwdata[15:0]) == audio_cfg.pilot_freq)
    else $error("pilot frequency differs from written value");

  chk_pilot_gate_on: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
    audio_cfg.pilot_active |-> $past(s_reg.control[`FTAPB_BIT_PILOT_ENABLE]))
    else $error("pilot active without component enable");

  chk_cts_ready_event: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    (s_reg.cts == CTS_BUSY && s_reg.busy_cnt == 4'h0) |=> (cts && s_reg.status[`FTAPB_EVT_CTS]))
    else $error("clear-to-send did not rise with its event");

  chk_cts_busy_after: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    (pready && $past(prop_hit) && !pslverr) |-> !cts [*4] ##1 cts)
    else $error("clear-to-send busy period wrong");

  chk_refuse_power_down: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    (access && prop_hit && cts && !s_reg.control[`FTAPB_BIT_POWERED_UP]) |=> (pready && pslverr))
    else $error("property access while powered down not refused");

  chk_attack_delay: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
    $rose(audio_cfg.compression_region) |-> $past(s_reg.attack_cnt) ==
      attack_limit($past(s_reg.attack_code)) - 20'h00001)
    else $error("compression entered before attack time");

  chk_left_mute_pass: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    !s_reg.line_mute[`FTAPB_BIT_LEFT_SILENCE] |=> (audio_out.left == $past(audio_in.left)))
    else $error("left output not passed while unmuted");

  chk_right_mute_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    s_reg.line_mute[`FTAPB_BIT_RIGHT_SILENCE] |=> (audio_out.right == 16'sh0000))
    else $error("right output not silenced while muted");

  chk_mute_write_value: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    (wr_taken && paddr[15:2] == `FTAPB_IDX_LINE_MUTE) |=> (s_reg.line_mute == $past(pwdata[1:0])))
    else $error("mute bits differ from written value");

  chk_emph_write_value: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
    (wr_taken && paddr[15:2] == `FTAPB_IDX_PREEMPHASIS) |=> (audio_cfg.emphasis_select == $past(pwdata[1:0])))
    else $error("emphasis differs from written value");

  chk_pilot_freq_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    !$past(wr_taken) |-> $stable(audio_cfg.pilot_freq))
    else $error("pilot frequency changed without a write");

  chk_pilot_needs_power: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
    audio_cfg.pilot_active |-> $past(s_reg.control[`FTAPB_BIT_POWERED_UP]))
    else $error("pilot active while powered down");

  chk_pilot_follows_enable: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
    (s_reg.control[`FTAPB_BIT_PILOT_ENABLE] && s_reg.control[`FTAPB_BIT_POWERED_UP]) |=> audio_cfg.pilot_active)
    else $error("pilot not active with component enable");

  chk_cts_stays_low: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    (!cts && s_reg.busy_cnt != 4'h0) |=> !cts)
    else $error("clear-to-send rose before busy time ended");

  chk_prop_waits_cts: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    (access && prop_hit && !cts) |=> !pready)
    else $error("property access answered while busy");

  chk_cts_event_sticky: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    (s_reg.status[`FTAPB_EVT_CTS] && !(access && pwrite && paddr[15:2] == `FTAPB_IDX_STATUS)) |=>
      s_reg.status[`FTAPB_EVT_CTS])
    else $error("clear-to-send event lost without a clear");

  chk_refused_no_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    (access && prop_hit && cts && !s_reg.control[`FTAPB_BIT_POWERED_UP]) |=> (cts && $stable({s_reg.line_mute,
      s_reg.emphasis_select, s_reg.pilot_freq, s_reg.drc_enable, s_reg.threshold, s_reg.attack_code})))
    else $error("refused access changed a property");

  chk_refused_event: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    (access && prop_hit && cts && !s_reg.control[`FTAPB_BIT_POWERED_UP]) |=> s_reg.status[`FTAPB_EVT_REFUSED])
    else $error("refused access not flagged");

  chk_limiter_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
    (wr_taken && paddr[15:2] == `FTAPB_IDX_DRC_ENABLE) |=>
      (audio_cfg.peak_clamp_on == $past(pwdata[`FTAPB_BIT_PEAK_CLAMP_ON])))
    else $error("limiter enable differs from written value");

  chk_compressor_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    (wr_taken && paddr[15:2] == `FTAPB_IDX_DRC_ENABLE) |=>
      (audio_cfg.compressor_on == $past(pwdata[`FTAPB_BIT_COMPRESSOR_ON])))
    else $error("compressor enable differs from written value");

  chk_comp_off_region: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    !audio_cfg.compressor_on |=> !audio_cfg.compression_region)
    else $error("compression while compressor bypassed");

  chk_thresh_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
    (wr_taken && paddr[15:2] == `FTAPB_IDX_COMP_THRESH) |=> (audio_cfg.threshold == $past(pwdata[15:0])))
    else $error("threshold differs from written value");

  chk_gain_below_thresh: assert property (@(posedge ref_clk) disable iff (!nrst) // R13
    !above_thresh |=> !audio_cfg.compression_region)
    else $error("compression while level below threshold");

  chk_attack_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
    (wr_taken && paddr[15:2] == `FTAPB_IDX_COMP_ATTACK) |=> (audio_cfg.attack_code == $past(pwdata[3:0])))
    else $error("attack code differs from written value");

  chk_entry_above_level: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
    $rose(audio_cfg.compression_region) |-> $past(above_thresh && audio_cfg.compressor_on))
    else $error("compression entered without level above threshold");

endmodule : ftapb_bank
`default_nettype wire

// ==== tb/ftapb_host_model.sv ====
// apb host model issuing property commands to the audio property bank
`timescale 1ns/1ns
`default_nettype none

module ftapb_host_model (
  input  wire logic        ref_clk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [15:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
  end

  // one transfer, held until pready is sampled high or 40 cycles pass
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic to);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    to = (pready !== 1'b1);
    q  = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : ftapb_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// register and audio path tests of the audio property bank
`timescale 1ns/1ns
`default_nettype none
`include "ftapb_defs.svh"

module tb_top;
  import ftapb_pkg::*;
  localparam int STEP = 4;
  logic                ref_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, cts, e;
  logic [15:0]         paddr;
  logic [31:0]         pwdata, prdata, q;
  ftapb_stereo_type    audio_in, audio_out;
  logic signed [15:0]  audio_level;
  ftapb_audio_cfg_type audio_cfg;
  int                  miscompares, samples_checked, n;
  logic [13:0]         idx [6] = '{`FTAPB_IDX_LINE_MUTE, `FTAPB_IDX_PREEMPHASIS, `FTAPB_IDX_PILOT_FREQ,
                                   `FTAPB_IDX_DRC_ENABLE, `FTAPB_IDX_COMP_THRESH, `FTAPB_IDX_COMP_ATTACK};
  logic [15:0]         rv  [6] = '{16'h0000, 16'h0000, 16'h4A38, 16'h0002, 16'hFFD8, 16'h0000};
  logic [15:0]         mk  [6] = '{16'h0003, 16'h0003, 16'hFFFF, 16'h0003, 16'hFFFF, 16'h000F};
  int                  ac  [3] = '{0, 3, 9};

  ftapb_bank #(.ATTACK_STEP_CYCLES(STEP)) ftapb_bank_inst (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .cts(cts), .audio_in(audio_in), .audio_level(audio_level),
    .audio_out(audio_out), .audio_cfg(audio_cfg));

  ftapb_host_model ftapb_host_model_inst (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] ba(input logic [13:0] i);
    return {i, 2'b00};
  endfunction : ba

  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask : chk

  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    logic to;
    ftapb_host_model_inst.xfer(w, a, d, q, e, to);
    if (to)
    begin
      $display("ERROR pready expected 1 seen 0");
      miscompares++;
      close_out();
    end
  endtask : acc

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] ex, input logic exe, input string nm);
    acc(1'b0, a, 32'h0000_0000);
    chk(nm, ex, q);
    chk({nm, "_err"}, exe, e);
  endtask : rd

  initial
  begin
    nrst = 1'b0;
    audio_in = '0;
    audio_level = 16'shFFE2;
    miscompares = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("cfg_reset", {8'h00, 16'h4A38, 3'b010, 16'hFFD8, 5'h00}, audio_cfg);
    rd(ba(`FTAPB_IDX_LINE_MUTE), 32'h0, 1'b1, "refused_read");
    wr(ba(`FTAPB_IDX_PILOT_FREQ), 32'h0000_1111);
    acc(1'b0, ba(`FTAPB_IDX_STATUS), 32'h0);
    chk("status_refused", 1'b1, q[1]);
    rd(16'h0010, 32'h0, 1'b1, "unmapped");
    wr(ba(`FTAPB_IDX_CONTROL), 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      rd(ba(idx[i]), rv[i], 1'b0, "prop_reset");
      wr(ba(idx[i]), 32'hFFFF_FFFF);
      rd(ba(idx[i]), mk[i], 1'b0, "prop_masked");
    end
    chk("cfg_all_on", {8'h03, 16'hFFFF, 3'b011, 16'hFFFF, 5'h1E}, audio_cfg);
    audio_in <= '{left: 16'h1234, right: 16'h5678};
    for (int m = 0; m < 4; m++)
    begin
      wr(ba(`FTAPB_IDX_LINE_MUTE), 32'(m));
      repeat (2) @(posedge ref_clk);
      chk("audio_out", {m[1] ? 16'h0 : 16'h1234, m[0] ? 16'h0 : 16'h5678}, audio_out);
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(ba(`FTAPB_IDX_PREEMPHASIS), 32'(p));
      repeat (2) @(posedge ref_clk);
      chk("emphasis", p[1:0], audio_cfg.emphasis_select);
    end
    wr(ba(`FTAPB_IDX_PILOT_FREQ), 32'h0000_03E8);
    repeat (2) @(posedge ref_clk);
    chk("pilot_off", {16'h03E8, 1'b0}, {audio_cfg.pilot_freq, audio_cfg.pilot_active});
    wr(ba(`FTAPB_IDX_CONTROL), 32'h3);
    repeat (2) @(posedge ref_clk);
    chk("pilot_on", 1'b1, audio_cfg.pilot_active);
    wr(ba(`FTAPB_IDX_STATUS), 32'h7);
    wr(ba(`FTAPB_IDX_MASK), 32'h0);
    wr(ba(`FTAPB_IDX_LINE_MUTE), 32'h0);
    chk("cts_busy", 1'b0, cts);
    n = 0;
    while (cts !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("cts_delay", 4, n);
    if (n == 20)
      close_out();
    rd(ba(`FTAPB_IDX_STATUS), 32'h1, 1'b0, "status_cts");
    chk("irq_masked", 1'b0, irq);
    wr(ba(`FTAPB_IDX_MASK), 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq_on", 1'b1, irq);
    wr(ba(`FTAPB_IDX_STATUS), 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq_clear", 1'b0, irq);
    wr(ba(`FTAPB_IDX_DRC_ENABLE), 32'h1);
    wr(ba(`FTAPB_IDX_COMP_THRESH), 32'h0000_FFEC);
    chk("drc_bits", 2'b01, {audio_cfg.peak_clamp_on, audio_cfg.compressor_on});
    for (int i = 0; i < 3; i++)
    begin
      wr(ba(`FTAPB_IDX_COMP_ATTACK), 32'(ac[i]));
      audio_level <= 16'sh0000;
      n = 0;
      while (audio_cfg.compression_region !== 1'b1 && n < 60)
      begin
        @(posedge ref_clk);
        n++;
      end
      chk("attack_cycles", 1'b1, n >= (ac[i] + 1) * STEP && n <= (ac[i] + 1) * STEP + 2);
      if (n == 60)
        close_out();
      audio_level <= 16'shFFE2;
      repeat (3) @(posedge ref_clk);
      chk("region_drop", 1'b0, audio_cfg.compression_region);
    end
    acc(1'b0, ba(`FTAPB_IDX_STATUS), 32'h0);
    chk("status_compress", 1'b1, q[2]);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("cfg_rerun", {8'h00, 16'h4A38, 3'b010, 16'hFFD8, 5'h00}, audio_cfg);
    chk("cts_rerun", 1'b1, cts);
    rd(ba(`FTAPB_IDX_DRC_ENABLE), 32'h0, 1'b1, "rerun_refused");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
